// file: inc/pfol_pkg.sv
/*
 Constants, register map and types of the protective field output logic.
 Assumes a 50 MHz system clock and one scan every 67 ms.
*/
package pfol_pkg;
   // Time base
   localparam int CLK_PERIOD_NS = 20;
   localparam int MS_PERIOD_NS = 1000000;
   localparam int MS_CYCLES = MS_PERIOD_NS / CLK_PERIOD_NS;
   localparam int DEBOUNCE_MS = 10;
   localparam int SCAN_PERIOD_MS = 67;
   localparam int RESP_MIN_MS = 134;
   localparam int RESP_MAX_MS = 30000;
   localparam int HOLD_MAX_MS = 10000;
   localparam int CFG_LOW_MS = 100;
   localparam int FLASH_HALF_MS = 250;
   localparam int INDEX_PULSE_CYCLES = 16;
   localparam logic [8:0] RESP_MIN_SCANS = 9'(RESP_MIN_MS / SCAN_PERIOD_MS);
   localparam logic [8:0] RESP_MAX_SCANS = 9'(RESP_MAX_MS / SCAN_PERIOD_MS);
   localparam logic [13:0] HOLD_MAX = 14'(HOLD_MAX_MS);
   // Widths
   localparam int NUM_FIELDS = 3;
   localparam int SEL_W = 4;
   localparam int DIST_W = 16;
   // Distance coding, values in mm
   localparam logic [15:0] DIST_NONE = 16'h0000;
   localparam logic [15:0] DIST_ERR_BLIND = 16'h0001;
   localparam logic [15:0] DIST_MIN_MM = 16'h0032;
   localparam logic [15:0] DIST_MAX_MM = 16'h61A8;
   // Register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_RESP = 8'h04;
   localparam logic [7:0] REG_HOLD = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0C;
   localparam logic [7:0] REG_IP = 8'h10;
   localparam logic [7:0] REG_MASK = 8'h14;
   localparam logic [7:0] REG_PORT = 8'h18;
   localparam logic [7:0] REG_LAST = 8'h1C;
   // Control fields and reset values
   localparam int CTRL_INDEX_EN_BIT = 0;
   localparam int CTRL_IN_INV_BIT = 1;
   localparam logic [1:0] CTRL_RST = 2'h1;
   localparam logic [31:0] IP_RST = 32'hC0A80001;
   localparam logic [31:0] MASK_RST = 32'hFFFFFF00;
   localparam logic [15:0] PORT_RST = 16'h0840;
   localparam logic [13:0] HOLD_RST = 14'h0000;
   // Bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {ST_BOOT, ST_READY, ST_FAULT} pfol_state_t;
endpackage

// file: inc/pfol_deb_if.sv
/*
 Carrier between the top and one input debouncer.
 Assumes the top drives the tick and the raw level.
*/
`timescale 1ns/1ns
interface pfol_deb_if;
   logic tick;
   logic raw;
   logic stable;
   modport ctl(output tick, output raw, input stable);
   modport deb(input tick, input raw, output stable);
endinterface

// file: design/pfol_debounce.sv
/*
 Debouncer for one switching input, counting millisecond ticks.
 Assumes raw is synchronous to sys_clk_i.
*/
`timescale 1ns/1ns
module pfol_debounce
   import pfol_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic srst_i,
   input wire logic clk_en_i,
   // Input levels
   pfol_deb_if.deb dif
);
   logic [3:0] cnt_reg;
   logic stable_reg;

   assign dif.stable = stable_reg;

   // A new level must stand unbroken for the full time
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         cnt_reg <= 4'h0;
         stable_reg <= 1'b0;
      end else if (clk_en_i) begin
         if (dif.raw == stable_reg) begin
            cnt_reg <= 4'h0;
         end else if (dif.tick) begin
            if (cnt_reg == 4'(DEBOUNCE_MS - 1)) begin
               stable_reg <= dif.raw;
               cnt_reg <= 4'h0;
            end else begin
               cnt_reg <= cnt_reg + 4'h1;
            end
         end
      end
   end
endmodule

// file: design/pfol_top.sv
/*
 Protective field output logic: set select, field outputs, ready line,
 LEDs, distance coding and AXI4-Lite registers.
 Assumes scan_done_i pulses once per scan with the field and distance
 results of that scan, and all inputs are synchronous to sys_clk_i.
*/
`timescale 1ns/1ns
module pfol_top
   import pfol_pkg::*;
#(
   parameter int MS_CYCLES_P = MS_CYCLES
) (
   // Clock, reset, enable
   input wire logic sys_clk_i,
   input wire logic srst_i,
   input wire logic clk_en_i,
   // Field set select pins
   input wire logic set_select_bit0_i,
   input wire logic set_select_bit1_i,
   input wire logic set_select_bit2_i,
   input wire logic set_select_bit3_i,
   // Scan results and device status
   input wire logic scan_done_i,
   input wire logic index_angle_i,
   input wire logic [pfol_pkg::NUM_FIELDS-1:0] field_hit_i,
   input wire logic object_i,
   input wire logic meas_err_i,
   input wire logic [3:0] meas_err_code_i,
   input wire logic [pfol_pkg::DIST_W-1:0] meas_mm_i,
   input wire logic boot_done_i,
   input wire logic fault_i,
   // Telegram requests
   input wire logic single_read_request_i,
   input wire logic continuous_output_toggle_i,
   input wire logic continuous_start_i,
   // Switching outputs and LEDs
   output logic field_a_infringed_n_o,
   output logic field_b_infringed_n_o,
   output logic field_c_infringed_n_o,
   output logic ready_index_line_o,
   output logic led_red_o,
   output logic led_green_o,
   output logic [pfol_pkg::SEL_W-1:0] active_set_o,
   // Measurement data out
   output logic scan_data_telegram_valid_o,
   output logic [pfol_pkg::DIST_W-1:0] scan_data_telegram_o,
   output logic [31:0] net_ip_o,
   output logic [31:0] net_mask_o,
   output logic [15:0] net_port_o,
   // AXI4-Lite slave
   input wire logic [31:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [31:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i
);
   localparam int MS_W = $clog2(MS_CYCLES_P + 1);

   pfol_state_t st_reg;
   logic [MS_W-1:0] ms_cnt_reg;
   logic ms_tick_reg;
   logic [1:0] ctrl_reg;
   logic [8:0] resp_reg;
   logic [13:0] hold_reg;
   logic [31:0] ip_reg, mask_reg;
   logic [15:0] port_reg;
   logic [SEL_W-1:0] sel_pins, deb_code;
   logic [NUM_FIELDS-1:0] filt_reg, field_n_reg;
   logic [6:0] cfg_cnt_reg;
   logic [4:0] idx_cnt_reg;
   logic [7:0] flash_cnt_reg;
   logic flash_reg;
   logic [DIST_W-1:0] enc, last_enc_reg;
   logic stream_reg;
   logic [7:0] aw_off_reg;
   logic aw_hi_reg;
   logic wr_fire, wr_cfg, wr_ok;
   logic [31:0] wdata_reg, wmerge;
   logic [3:0] wstrb_reg;
   logic [31:0] rd_data;
   logic rd_ok;
   logic [8:0] need;

   assign sel_pins = {set_select_bit3_i, set_select_bit2_i, set_select_bit1_i,
                      set_select_bit0_i};

   // Millisecond tick shared by debounce, hold, config and flash timers
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         ms_cnt_reg <= '0;
         ms_tick_reg <= 1'b0;
      end else if (clk_en_i) begin
         ms_tick_reg <= (ms_cnt_reg == MS_W'(MS_CYCLES_P - 1));
         if (ms_cnt_reg == MS_W'(MS_CYCLES_P - 1)) begin
            ms_cnt_reg <= '0;
         end else begin
            ms_cnt_reg <= ms_cnt_reg + MS_W'(1);
         end
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < SEL_W; gi++) begin : g_deb
         pfol_deb_if dif();
         assign dif.tick = ms_tick_reg;
         assign dif.raw = sel_pins[gi] ^ ctrl_reg[CTRL_IN_INV_BIT];
         assign deb_code[gi] = dif.stable;
         pfol_debounce u_deb (
            .sys_clk_i(sys_clk_i),
            .srst_i(srst_i),
            .clk_en_i(clk_en_i),
            .dif(dif)
         );
      end
   endgenerate

   // Debounced code, bit 0 least significant, is the set index minus one
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         active_set_o <= '0;
      end else if (clk_en_i && scan_done_i) begin
         active_set_o <= deb_code;
      end
   end

   // Operating state; a fault holds until reset
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         st_reg <= ST_BOOT;
      end else if (clk_en_i) begin
         case (st_reg)
            ST_BOOT: begin
               if (fault_i) begin
                  st_reg <= ST_FAULT;
               end else if (boot_done_i) begin
                  st_reg <= ST_READY;
               end
            end
            ST_READY: begin
               if (fault_i) begin
                  st_reg <= ST_FAULT;
               end
            end
            ST_FAULT: st_reg <= ST_FAULT;
            default: st_reg <= ST_FAULT;
         endcase
      end
   end

   // Scans of confirmation; the minimum setting answers on the first scan
   assign need = (resp_reg <= 9'h001) ? 9'h001 : resp_reg - 9'h001;

   generate
      for (gi = 0; gi < NUM_FIELDS; gi++) begin : g_field
         logic [8:0] run_reg;
         logic [13:0] hold_cnt_reg;
         logic infr_reg;
         // One process per field flop keeps each bit of filt_reg single-driven
         assign filt_reg[gi] = infr_reg;
         always_ff @(posedge sys_clk_i) begin
            if (srst_i) begin
               run_reg <= '0;
               hold_cnt_reg <= '0;
               infr_reg <= 1'b1;
            end else if (clk_en_i) begin
               if (scan_done_i) begin
                  if (field_hit_i[gi]) begin
                     if (run_reg != RESP_MAX_SCANS) begin
                        run_reg <= run_reg + 9'h001;
                     end
                     if (run_reg + 9'h001 >= need) begin
                        infr_reg <= 1'b1;
                     end
                     hold_cnt_reg <= hold_reg;
                  end else begin
                     run_reg <= '0;
                     if (hold_cnt_reg == 14'h0000) begin
                        infr_reg <= 1'b0;
                     end
                  end
               end else if (ms_tick_reg && hold_cnt_reg != 14'h0000) begin
                  hold_cnt_reg <= hold_cnt_reg - 14'h0001;
               end
            end
         end
      end
   endgenerate

   // Outputs only show fields once ready; otherwise all infringed
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         field_n_reg <= '0;
      end else if (clk_en_i) begin
         field_n_reg <= (st_reg == ST_READY) ? ~filt_reg : '0;
      end
   end
   assign field_a_infringed_n_o = field_n_reg[0];
   assign field_b_infringed_n_o = field_n_reg[1];
   assign field_c_infringed_n_o = field_n_reg[2];

   // Index pulse and configuration drop on the ready line
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         idx_cnt_reg <= '0;
      end else if (clk_en_i) begin
         if (index_angle_i && ctrl_reg[CTRL_INDEX_EN_BIT] && idx_cnt_reg == 5'h00) begin
            idx_cnt_reg <= 5'(INDEX_PULSE_CYCLES);
         end else if (idx_cnt_reg != 5'h00) begin
            idx_cnt_reg <= idx_cnt_reg - 5'h01;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         cfg_cnt_reg <= '0;
      end else if (clk_en_i) begin
         if (wr_cfg) begin
            cfg_cnt_reg <= 7'(CFG_LOW_MS);
         end else if (ms_tick_reg && cfg_cnt_reg != 7'h00) begin
            cfg_cnt_reg <= cfg_cnt_reg - 7'h01;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         ready_index_line_o <= 1'b0;
      end else if (clk_en_i) begin
         ready_index_line_o <= (st_reg == ST_READY) && cfg_cnt_reg == 7'h00
                               && idx_cnt_reg == 5'h00;
      end
   end

   // Status LEDs
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         flash_cnt_reg <= '0;
         flash_reg <= 1'b0;
      end else if (clk_en_i && ms_tick_reg) begin
         if (flash_cnt_reg == 8'(FLASH_HALF_MS - 1)) begin
            flash_cnt_reg <= '0;
            flash_reg <= ~flash_reg;
         end else begin
            flash_cnt_reg <= flash_cnt_reg + 8'h01;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         led_red_o <= 1'b0;
         led_green_o <= 1'b0;
      end else if (clk_en_i) begin
         led_green_o <= (st_reg == ST_READY);
         led_red_o <= (st_reg == ST_READY) ? |filt_reg : (st_reg == ST_FAULT) && flash_reg;
      end
   end

   // Distance coding in millimetres; blind zone reports an error code
   always_comb begin
      if (meas_err_i) begin
         enc = DIST_W'(meas_err_code_i) + 16'h0001;
      end else if (!object_i || meas_mm_i > DIST_MAX_MM) begin
         enc = DIST_NONE;
      end else if (meas_mm_i < DIST_MIN_MM) begin
         enc = DIST_ERR_BLIND;
      end else begin
         enc = meas_mm_i;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         last_enc_reg <= DIST_NONE;
         stream_reg <= 1'b0;
         scan_data_telegram_valid_o <= 1'b0;
         scan_data_telegram_o <= DIST_NONE;
      end else if (clk_en_i) begin
         if (scan_done_i) begin
            last_enc_reg <= enc;
         end
         if (continuous_output_toggle_i) begin
            stream_reg <= continuous_start_i;
         end
         scan_data_telegram_valid_o <= 1'b0;
         if (scan_done_i && stream_reg) begin
            scan_data_telegram_valid_o <= 1'b1;
            scan_data_telegram_o <= enc;
         end else if (single_read_request_i) begin
            scan_data_telegram_valid_o <= 1'b1;
            scan_data_telegram_o <= last_enc_reg;
         end
      end
   end

   // Bus write path: address and data taken in either order
   assign wr_fire = !s_axi_awready_o && !s_axi_wready_o && !s_axi_bvalid_o;
   assign wr_ok = !aw_hi_reg && aw_off_reg <= REG_LAST && aw_off_reg[1:0] == 2'h0
                  && aw_off_reg != REG_STATUS && aw_off_reg != REG_LAST;
   assign wr_cfg = wr_fire && wr_ok && aw_off_reg <= REG_HOLD;
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         wmerge[8*b +: 8] = wstrb_reg[b] ? wdata_reg[8*b +: 8] : rd_data_w(b);
      end
   end

   function automatic logic [7:0] rd_data_w(input int b);
      logic [31:0] cur;
      case (aw_off_reg)
         REG_CTRL: cur = {30'h0, ctrl_reg};
         REG_RESP: cur = {23'h0, resp_reg};
         REG_HOLD: cur = {18'h0, hold_reg};
         REG_IP: cur = ip_reg;
         REG_MASK: cur = mask_reg;
         REG_PORT: cur = {16'h0, port_reg};
         default: cur = 32'h0;
      endcase
      return cur[8*b +: 8];
   endfunction

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         s_axi_awready_o <= 1'b1;
         s_axi_wready_o <= 1'b1;
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o <= RESP_OKAY;
         aw_off_reg <= '0;
         aw_hi_reg <= 1'b0;
         wdata_reg <= '0;
         wstrb_reg <= '0;
      end else if (clk_en_i) begin
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            s_axi_awready_o <= 1'b0;
            aw_off_reg <= s_axi_awaddr_i[7:0];
            aw_hi_reg <= |s_axi_awaddr_i[31:8];
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            s_axi_wready_o <= 1'b0;
            wdata_reg <= s_axi_wdata_i;
            wstrb_reg <= s_axi_wstrb_i;
         end
         if (wr_fire) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid_o && s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o <= 1'b1;
         end
      end
   end

   // Register storage; timing settings are clamped to their legal span
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         ctrl_reg <= CTRL_RST;
         resp_reg <= RESP_MIN_SCANS;
         hold_reg <= HOLD_RST;
         ip_reg <= IP_RST;
         mask_reg <= MASK_RST;
         port_reg <= PORT_RST;
      end else if (clk_en_i && wr_fire && wr_ok) begin
         case (aw_off_reg)
            REG_CTRL: ctrl_reg <= wmerge[1:0];
            REG_RESP: resp_reg <= (wmerge < 32'(RESP_MIN_SCANS)) ? RESP_MIN_SCANS :
                         (wmerge > 32'(RESP_MAX_SCANS)) ? RESP_MAX_SCANS : wmerge[8:0];
            REG_HOLD: hold_reg <= (wmerge > 32'(HOLD_MAX)) ? HOLD_MAX : wmerge[13:0];
            REG_IP: ip_reg <= wmerge;
            REG_MASK: mask_reg <= wmerge;
            REG_PORT: port_reg <= wmerge[15:0];
            default: ctrl_reg <= ctrl_reg;
         endcase
      end
   end
   assign net_ip_o = ip_reg;
   assign net_mask_o = mask_reg;
   assign net_port_o = port_reg;

   // Bus read path
   always_comb begin
      rd_ok = (s_axi_araddr_i[31:8] == 24'h0);
      case (s_axi_araddr_i[7:0])
         REG_CTRL: rd_data = {30'h0, ctrl_reg};
         REG_RESP: rd_data = {23'h0, resp_reg};
         REG_HOLD: rd_data = {18'h0, hold_reg};
         REG_STATUS: rd_data = {17'h0, filt_reg, ready_index_line_o, field_n_reg,
                                active_set_o, 2'h0, st_reg};
         REG_IP: rd_data = ip_reg;
         REG_MASK: rd_data = mask_reg;
         REG_PORT: rd_data = {16'h0, port_reg};
         REG_LAST: rd_data = {16'h0, last_enc_reg};
         default: begin
            rd_data = 32'h0;
            rd_ok = 1'b0;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         s_axi_arready_o <= 1'b1;
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o <= '0;
         s_axi_rresp_o <= RESP_OKAY;
      end else if (clk_en_i) begin
         if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o <= rd_ok ? rd_data : 32'h0;
            s_axi_rresp_o <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_arready_o <= 1'b1;
         end
      end
   end

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (srst_i || !clk_en_i);

   sequence s_index_start;
      st_reg == ST_READY && ctrl_reg[CTRL_INDEX_EN_BIT] && index_angle_i
      && idx_cnt_reg == 5'h00;
   endsequence
   sequence s_line_low8;
      !ready_index_line_o [*8];
   endsequence

   AST_NOT_READY_INFRINGED: assert property (st_reg != ST_READY |=> field_n_reg == 3'h0)
      else $error("outputs not infringed outside ready");
   AST_FIELD_FOLLOWS: assert property (st_reg == ST_READY |=> field_n_reg == ~$past(filt_reg))
      else $error("output does not follow field");
   AST_FAULT_LINE_LOW: assert property (st_reg == ST_FAULT |=> !ready_index_line_o)
      else $error("ready line high in fault");
   AST_INDEX_PULSE: assert property (s_index_start |=> ##1 s_line_low8)
      else $error("index pulse too short");
   AST_CFG_DROP: assert property (wr_cfg |=> ##1 !ready_index_line_o)
      else $error("config write did not drop ready");
   AST_SET_APPLY: assert property (scan_done_i |=> active_set_o == $past(deb_code))
      else $error("set not applied at scan");
   AST_SET_HOLD: assert property (!scan_done_i |=> $stable(active_set_o))
      else $error("set changed between scans");
   AST_SINGLE_READ: assert property (single_read_request_i && !(scan_done_i && stream_reg)
      |=> scan_data_telegram_valid_o && scan_data_telegram_o == $past(last_enc_reg))
      else $error("single read not last scan");
   AST_STREAM: assert property (scan_done_i && stream_reg |=> scan_data_telegram_valid_o)
      else $error("stream missed a scan");
   AST_FAULT_LED: assert property (st_reg == ST_FAULT |=> !led_green_o)
      else $error("green lit in fault");
endmodule

// file: test/pfol_ctrl_model.sv
/*
 Downstream controller model: drives the set code, takes telegrams.
 Assumes the bench says when the device reached readiness.
*/
`timescale 1ns/1ns
module pfol_ctrl_model (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic srst_i,
   // Controls from the bench
   input wire logic [3:0] set_code_i,
   input wire logic ready_seen_i,
   input wire logic tel_valid_i,
   input wire logic [15:0] tel_data_i,
   // Pins and received data
   output logic [3:0] sel_o,
   output logic [15:0] rx_last_o,
   output logic [7:0] rx_count_o
);
   // Plain binary code, bit0 least significant; never writes parameters
   assign sel_o = set_code_i;
   // Telegrams before readiness carry no meaning and are dropped
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         rx_count_o <= 8'h00;
         rx_last_o <= 16'h0000;
      end else if (tel_valid_i && ready_seen_i) begin
         rx_count_o <= rx_count_o + 8'h01;
         rx_last_o <= tel_data_i;
      end
   end
endmodule

// file: test/protective_field_output_logic_test.sv
/*
 Self-checking bench of pfol_top with a controller model.
 Assumes MS_CYCLES_P of 10, so one millisecond is ten cycles.
*/
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; $display("mismatch t=%0t %h %h", $time, a, b); end end
module protective_field_output_logic_test;
   import pfol_pkg::*;
   logic sys_clk_i = 0, srst_i = 1, scan = 0, idx = 0, obj = 0, err = 0, boot = 0, flt = 0;
   logic sreq = 0, ctog = 0, cst = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, booted = 0, cen = 1;
   logic fa, fb, fc, rdy, red, grn, tv, awr, wr_o, bv, arr, rv;
   logic [1:0] bresp, rresp, rsp;
   logic [2:0] hit = 0;
   logic [3:0] ec = 0, code = 0, sel, aset, old;
   logic [15:0] mm = 0, td, port, rx_last, m;
   logic [7:0] rx_cnt, c0;
   logic [31:0] aw = 0, wd = 0, ar = 0, rd, ip, rdata, mask;
   int bad_count = 0, cmp_count = 0;
   always #10 sys_clk_i = ~sys_clk_i;
   pfol_top #(.MS_CYCLES_P(10)) uut (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .clk_en_i(cen),
      .set_select_bit0_i(sel[0]), .set_select_bit1_i(sel[1]), .set_select_bit2_i(sel[2]),
      .set_select_bit3_i(sel[3]), .scan_done_i(scan), .index_angle_i(idx), .field_hit_i(hit),
      .object_i(obj), .meas_err_i(err), .meas_err_code_i(ec), .meas_mm_i(mm),
      .boot_done_i(boot), .fault_i(flt), .single_read_request_i(sreq),
      .continuous_output_toggle_i(ctog), .continuous_start_i(cst),
      .field_a_infringed_n_o(fa), .field_b_infringed_n_o(fb), .field_c_infringed_n_o(fc),
      .ready_index_line_o(rdy), .led_red_o(red), .led_green_o(grn), .active_set_o(aset),
      .scan_data_telegram_valid_o(tv), .scan_data_telegram_o(td), .net_ip_o(ip),
      .net_mask_o(mask), .net_port_o(port), .s_axi_awaddr_i(aw), .s_axi_awvalid_i(awv),
      .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv),
      .s_axi_wready_o(wr_o), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
      .s_axi_araddr_i(ar), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
      .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr));
   pfol_ctrl_model ctrl (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .set_code_i(code),
      .ready_seen_i(booted), .tel_valid_i(tv), .tel_data_i(td), .sel_o(sel),
      .rx_last_o(rx_last), .rx_count_o(rx_cnt));
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      aw <= a; wd <= d; awv <= 1; wv <= 1; br <= 1;
      forever begin
         @(posedge sys_clk_i);
         if (awr) awv <= 0;
         if (wr_o) wv <= 0;
         if (bv) break;
      end
      rsp = bresp;
      br <= 0;
      tick(1);
   endtask
   task automatic rdr(input logic [31:0] a);
      ar <= a; arv <= 1; rr <= 1;
      forever begin
         @(posedge sys_clk_i);
         if (arr) arv <= 0;
         if (rv) break;
      end
      rd = rdata;
      rsp = rresp;
      rr <= 0;
      tick(1);
   endtask
   task automatic sc(input logic [2:0] h, input logic o, input logic e, input logic [3:0] c,
                     input logic [15:0] d);
      hit <= h; obj <= o; err <= e; ec <= c; mm <= d; scan <= 1;
      tick(1);
      scan <= 0;
      tick(3);
   endtask
   function automatic logic [15:0] dcode(input logic o, input logic e, input logic [3:0] c,
                                         input logic [15:0] d);
      if (e) return 16'(c) + 16'h0001;
      if (!o || d > DIST_MAX_MM) return DIST_NONE;
      if (d < DIST_MIN_MM) return 16'h0001;
      return d;
   endfunction
   task end_sim;
      $display("counts bad=%0d cmp=%0d", bad_count, cmp_count);
      if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      void'($urandom(55));
      tick(10);
      srst_i <= 0;
      tick(3);
      `CHK({fa, fb, fc, rdy}, 4'h0)
      `CHK(ip, 32'hC0A80001)
      `CHK(port, 16'h0840)
      `CHK(mask, 32'hFFFFFF00)
      boot <= 1;
      tick(1);
      boot <= 0;
      booted <= 1;
      tick(5);
      // Fields stay infringed until the first scan evaluates them, so red is lit
      `CHK({rdy, grn, red}, 3'b111)
      $display("test boot done");
      for (int i = 0; i < 12; i++) begin
         m = (i < 8) ? 16'(i) : 16'($urandom % 8);
         sc(m[2:0], 0, 0, 0, 0);
         `CHK({fc, fb, fa}, ~m[2:0])
         `CHK(red, |m[2:0])
      end
      $display("test fields done");
      idx <= 1;
      tick(1);
      idx <= 0;
      tick(2);
      `CHK(rdy, 1'b0)
      tick(18);
      `CHK(rdy, 1'b1)
      $display("test index done");
      ctog <= 1; cst <= 1;
      tick(1);
      ctog <= 0;
      tick(2);
      c0 = rx_cnt;
      for (int i = 0; i < 6; i++) begin
         m = i == 0 ? 16'(50 + $urandom % 4951) : i == 1 ? 16'd20 : i == 2 ? 16'd30000 : 16'd25000;
         ec <= 4'($urandom);
         tick(1);
         sc(0, i != 5, i == 4, ec, m);
         `CHK(rx_last, dcode(i != 5, i == 4, ec, m))
         `CHK(rx_cnt, c0 + 8'(i + 1))
      end
      sreq <= 1;
      tick(1);
      sreq <= 0;
      tick(2);
      `CHK(rx_cnt, c0 + 8'd7)
      `CHK(rx_last, DIST_NONE)
      ctog <= 1; cst <= 0;
      tick(1);
      ctog <= 0;
      sc(0, 1, 0, 0, 16'd100);
      `CHK(rx_cnt, c0 + 8'd7)
      sreq <= 1;
      tick(1);
      sreq <= 0;
      tick(2);
      `CHK(rx_last, 16'd100)
      $display("test telegrams done");
      for (int k = 0; k < 3; k++) begin
         old = aset;
         code <= (k == 0) ? 4'hF : 4'($urandom);
         tick(40);
         sc(0, 0, 0, 0, 0);
         if (code != old) `CHK(aset, old)
         tick(80);
         sc(0, 0, 0, 0, 0);
         sc(0, 0, 0, 0, 0);
         `CHK(aset, code)
      end
      $display("test select done");
      rdr(32'h40);
      `CHK(rsp, RESP_SLVERR)
      rdr(32'(REG_CTRL));
      `CHK(rd[1:0], 2'h1)
      wr(32'(REG_RESP), 32'h3);
      `CHK(rsp, RESP_OKAY)
      tick(10);
      `CHK(rdy, 1'b0)
      tick(1100);
      `CHK(rdy, 1'b1)
      sc(3'h1, 0, 0, 0, 0);
      `CHK(fa, 1'b1)
      sc(3'h1, 0, 0, 0, 0);
      `CHK(fa, 1'b0)
      wr(32'(REG_HOLD), 32'h5);
      sc(3'h1, 0, 0, 0, 0);
      sc(3'h0, 0, 0, 0, 0);
      `CHK(fa, 1'b0)
      tick(60);
      sc(3'h0, 0, 0, 0, 0);
      `CHK(fa, 1'b1)
      $display("test config done");
      cen <= 0;
      sc(3'h1, 0, 0, 0, 0);
      sc(3'h1, 0, 0, 0, 0);
      `CHK(fa, 1'b1)
      cen <= 1;
      $display("test freeze done");
      flt <= 1;
      tick(5);
      `CHK({fc, fb, fa, rdy, grn}, 5'h00)
      $display("test fault done");
      end_sim;
   end
   initial begin
      tick(20000);
      bad_count++;
      end_sim;
   end
endmodule
